// ### logic/motion_regs.svh
// constants for the staged positioning command link and its controller
`ifndef MOTION_REGS_SVH
`define MOTION_REGS_SVH

// frame layout, bit positions inside the 64-bit frame (byte n at bits 8n+7..8n)
`define FRM_START_BIT 0
`define FRM_SERVO_BIT 1
`define FRM_CODE_LSB 8
`define FRM_INC_BIT 24
`define FRM_DATA_LSB 32

// command codes
`define CODE_NONE 4'h0
`define CODE_NOTCH 4'h3
`define CODE_MULTI 4'h4

// stage table limits and defaults
`define STAGE_MAX 5'h10
`define POS_MAX 32'h05F5_E0FF
`define SPD_MIN 18'h0_0001
`define SPD_MAX 18'h3_A980
`define SPD_DEF 18'h0_5DC0

// setting indices on the parameter port
`define PIX_COUNT 6'h00
`define PIX_FEED 6'h01
`define PIX_POS0 6'h02
`define PIX_SPD0 6'h12
`define PIX_NOTCH0 6'h22
`define PIX_NOTCH1 6'h23

// controller registers, byte offsets
`define REG_TARGET 8'h00
`define REG_CMD 8'h04
`define REG_PIDX 8'h08
`define REG_PDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_POS 8'h14

// controller command register fields
`define CMD_INC_BIT 4
`define CMD_SERVO_BIT 8

`endif

// ### logic/motion_pkg.sv
// types for the master and device ends of the positioning command link, each end using its own state type
`default_nettype none
package motion_pkg;
    typedef enum logic [1:0] {DEV_IDLE, DEV_NOTCH, DEV_MULTI} dev_state_t;
    typedef enum logic [2:0] {MS_IDLE, MS_CLEAR, MS_DATA, MS_CODE, MS_START} mst_state_t;
    typedef logic signed [31:0] pos_t;
    typedef logic [17:0] speed_t;
endpackage
`default_nettype wire

// ### logic/motion_if.sv
// link between the network master and the positioning device
`timescale 1ns/1ns
`default_nettype none
interface motion_if;
    logic [63:0] frame;
    logic param_wr;
    logic [5:0] param_idx;
    logic [31:0] param_data;
    logic busy;
    logic [1:0] notch;
    logic [4:0] stage;
    logic [31:0] position;

    modport dev (
        input frame,
        input param_wr,
        input param_idx,
        input param_data,
        output busy,
        output notch,
        output stage,
        output position
    );

    modport mst (
        output frame,
        output param_wr,
        output param_idx,
        output param_data,
        input busy,
        input notch,
        input stage,
        input position
    );
endinterface
`default_nettype wire

// ### logic/motion_dev.sv
// device end: decodes command frames and runs notch or staged positioning
//
// Functional notes
// - master clears command code before a command
// - master holds servo-on before starting movement
// - relative target is present position plus data
// - target data in bytes 4-7, captured at start
// - code 3 runs positioning with notch outputs
// - code 4 runs multi-speed positioning
// - code written last; start on start-bit rise
// - reaching stage position switches to its speed
// - up to 16 stages, count 0..16, default 0
// - stage positions 0..99,999,999, default zero
// - speeds 1..240,000, default 24,000
// - master leaves stage settings alone while running
// - two notch outputs set when passing notch
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs.svh"
module motion_dev (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    motion_if.dev LINK,
    input wire motion_pkg::pos_t AXIS_POS,
    input wire logic AXIS_DONE,
    output motion_pkg::pos_t AXIS_TARGET,
    output motion_pkg::speed_t AXIS_SPEED,
    output logic AXIS_GO,
    output logic AXIS_RUN
);
    import motion_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // frame fields

    logic start_bit;
    logic servo_bit;
    logic [3:0] code_field;
    logic inc_bit;
    pos_t data_field;

    assign start_bit = LINK.frame[`FRM_START_BIT];
    assign servo_bit = LINK.frame[`FRM_SERVO_BIT];
    assign code_field = LINK.frame[`FRM_CODE_LSB +: 4];
    assign inc_bit = LINK.frame[`FRM_INC_BIT];
    assign data_field = pos_t'(LINK.frame[`FRM_DATA_LSB +: 32]);

    ////////////////////////////////////////////////////////////////////////////////
    // settings

    logic [4:0] count_reg;
    speed_t feed_reg;
    pos_t stage_pos_reg [16];
    speed_t stage_spd_reg [16];
    pos_t notch_pos_reg [2];
    logic [5:0] pidx;
    logic [31:0] pdata;
    logic spd_ok;
    logic pos_ok;

    assign pidx = LINK.param_idx;
    assign pdata = LINK.param_data;
    // out-of-range writes are dropped so the table never holds an illegal value
    assign spd_ok = pdata >= {14'h0000, `SPD_MIN} && pdata <= {14'h0000, `SPD_MAX};
    assign pos_ok = pdata <= `POS_MAX;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            count_reg <= 5'h00;
        end else if (LINK.param_wr && pidx == `PIX_COUNT && pdata <= 32'(`STAGE_MAX)) begin
            count_reg <= pdata[4:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            feed_reg <= `SPD_DEF;
        end else if (LINK.param_wr && pidx == `PIX_FEED && spd_ok) begin
            feed_reg <= pdata[17:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < 16; i++) begin
                stage_pos_reg[i] <= 32'sh0000_0000;
                stage_spd_reg[i] <= `SPD_DEF;
            end
        end else if (LINK.param_wr) begin
            for (int i = 0; i < 16; i++) begin
                if (pidx == `PIX_POS0 + 6'(i) && pos_ok) begin
                    stage_pos_reg[i] <= pos_t'(pdata);
                end
                if (pidx == `PIX_SPD0 + 6'(i) && spd_ok) begin
                    stage_spd_reg[i] <= pdata[17:0];
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            notch_pos_reg[0] <= 32'sh0000_0000;
            notch_pos_reg[1] <= 32'sh0000_0000;
        end else if (LINK.param_wr && pidx == `PIX_NOTCH0) begin
            notch_pos_reg[0] <= pos_t'(pdata);
        end else if (LINK.param_wr && pidx == `PIX_NOTCH1) begin
            notch_pos_reg[1] <= pos_t'(pdata);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // command start

    logic start_d_reg;
    logic start_rise;
    logic accept;
    pos_t target_next;
    dev_state_t state_reg;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            start_d_reg <= 1'b0;
        end else begin
            start_d_reg <= start_bit;
        end
    end

    assign start_rise = start_bit && !start_d_reg;
    // a rise while a move is under way is ignored, never queued
    assign accept = start_rise && servo_bit && state_reg == DEV_IDLE
        && (code_field == `CODE_NOTCH || code_field == `CODE_MULTI);
    assign target_next = inc_bit ? AXIS_POS + data_field : data_field;

    ////////////////////////////////////////////////////////////////////////////////
    // move control

    logic dir_up_reg;
    pos_t start_pos_reg;
    logic [4:0] stage_reg;
    logic stage_live;
    logic stage_hit;
    pos_t stage_pos;

    assign stage_live = stage_reg < count_reg;
    assign stage_pos = stage_pos_reg[stage_reg[3:0]];
    assign stage_hit = state_reg == DEV_MULTI && stage_live
        && (dir_up_reg ? AXIS_POS >= stage_pos : AXIS_POS <= stage_pos);

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_reg <= DEV_IDLE;
        end else begin
            unique case (state_reg)
                DEV_IDLE: begin
                    if (accept) begin
                        state_reg <= code_field == `CODE_MULTI ? DEV_MULTI : DEV_NOTCH;
                    end
                end
                DEV_NOTCH, DEV_MULTI: begin
                    // dropping servo-on also ends the move
                    if (AXIS_DONE || !servo_bit) begin
                        state_reg <= DEV_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            AXIS_TARGET <= 32'sh0000_0000;
            dir_up_reg <= 1'b1;
            start_pos_reg <= 32'sh0000_0000;
        end else if (accept) begin
            AXIS_TARGET <= target_next;
            dir_up_reg <= target_next >= AXIS_POS;
            start_pos_reg <= AXIS_POS;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            AXIS_SPEED <= `SPD_DEF;
            stage_reg <= 5'h00;
        end else if (accept) begin
            AXIS_SPEED <= feed_reg;
            stage_reg <= 5'h00;
        end else if (stage_hit) begin
            AXIS_SPEED <= stage_spd_reg[stage_reg[3:0]];
            stage_reg <= stage_reg + 5'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            AXIS_GO <= 1'b0;
        end else begin
            AXIS_GO <= accept;
        end
    end

    assign AXIS_RUN = state_reg != DEV_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    // notch outputs

    logic [1:0] notch_reg;

    for (genvar k = 0; k < 2; k++) begin : g_notch
        logic passed;
        assign passed = dir_up_reg
            ? (start_pos_reg < notch_pos_reg[k] && AXIS_POS >= notch_pos_reg[k])
            : (start_pos_reg > notch_pos_reg[k] && AXIS_POS <= notch_pos_reg[k]);
        always_ff @(posedge SYS_CLK) begin
            if (SYS_RST) begin
                notch_reg[k] <= 1'b0;
            end else if (accept) begin
                notch_reg[k] <= 1'b0;
            end else if (state_reg == DEV_NOTCH && passed) begin
                notch_reg[k] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status back to the master

    logic [31:0] pos_reg;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pos_reg <= 32'h0000_0000;
        end else begin
            pos_reg <= AXIS_POS;
        end
    end

    // busy lets the master keep the stage table still during a move
    assign LINK.busy = AXIS_RUN;
    assign LINK.notch = notch_reg;
    assign LINK.stage = stage_reg;
    assign LINK.position = pos_reg;
endmodule
`default_nettype wire

// ### logic/motion_mst.sv
// master end: AHB-Lite registers that build command frames and settings writes
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs.svh"
module motion_mst (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    motion_if.mst LINK
);
    import motion_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave, zero wait states

    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic take;
    logic [31:0] rd_value;
    logic [31:0] target_reg;
    logic [31:0] cmd_reg;
    logic [5:0] pidx_reg;
    mst_state_t mstate_reg;
    logic cmd_wr;
    logic pdata_wr;

    assign take = HSEL && HTRANS[1] && HREADY;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take && HWRITE && HSIZE == 3'b010;
            wr_addr_reg <= HADDR[7:0];
        end
    end

    always_comb begin
        rd_value = 32'h0000_0000;
        unique case (HADDR[7:0])
            `REG_TARGET: rd_value = target_reg;
            `REG_CMD: rd_value = cmd_reg;
            `REG_PIDX: rd_value = {26'h000_0000, pidx_reg};
            `REG_STATUS: rd_value = {24'h00_0000, LINK.stage, LINK.notch,
                LINK.busy || mstate_reg != MS_IDLE};
            `REG_POS: rd_value = LINK.position;
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (take && !HWRITE) begin
            HRDATA <= rd_value;
        end
    end

    // a new command or a settings write is dropped while a move or sequence runs
    assign cmd_wr = wr_pend_reg && wr_addr_reg == `REG_CMD
        && mstate_reg == MS_IDLE && !LINK.busy;
    assign pdata_wr = wr_pend_reg && wr_addr_reg == `REG_PDATA
        && mstate_reg == MS_IDLE && !LINK.busy;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            target_reg <= 32'h0000_0000;
            cmd_reg <= 32'h0000_0000;
            pidx_reg <= 6'h00;
        end else if (wr_pend_reg && wr_addr_reg == `REG_TARGET) begin
            target_reg <= HWDATA;
        end else if (cmd_wr) begin
            cmd_reg <= HWDATA & 32'h0000_011F;
        end else if (wr_pend_reg && wr_addr_reg == `REG_PIDX) begin
            pidx_reg <= HWDATA[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // settings writes

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            LINK.param_wr <= 1'b0;
            LINK.param_idx <= 6'h00;
            LINK.param_data <= 32'h0000_0000;
        end else begin
            LINK.param_wr <= pdata_wr;
            if (pdata_wr) begin
                LINK.param_idx <= pidx_reg;
                LINK.param_data <= HWDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame sequence: clear code, servo on, data, code, then start rise

    logic [63:0] frame_reg;

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mstate_reg <= MS_IDLE;
            frame_reg <= 64'h0000_0000_0000_0000;
        end else begin
            unique case (mstate_reg)
                MS_IDLE: begin
                    if (cmd_wr) begin
                        mstate_reg <= MS_CLEAR;
                    end
                end
                MS_CLEAR: begin
                    frame_reg[`FRM_START_BIT] <= 1'b0;
                    frame_reg[`FRM_CODE_LSB +: 4] <= `CODE_NONE;
                    frame_reg[`FRM_SERVO_BIT] <= cmd_reg[`CMD_SERVO_BIT];
                    mstate_reg <= MS_DATA;
                end
                MS_DATA: begin
                    frame_reg[`FRM_INC_BIT] <= cmd_reg[`CMD_INC_BIT];
                    frame_reg[`FRM_DATA_LSB +: 32] <= target_reg;
                    mstate_reg <= MS_CODE;
                end
                MS_CODE: begin
                    frame_reg[`FRM_CODE_LSB +: 4] <= cmd_reg[3:0];
                    mstate_reg <= MS_START;
                end
                MS_START: begin
                    // start stays high until the next command clears it
                    frame_reg[`FRM_START_BIT] <= 1'b1;
                    mstate_reg <= MS_IDLE;
                end
            endcase
        end
    end

    assign LINK.frame = frame_reg;
endmodule
`default_nettype wire

// ### sim/motion_link_sva.sv
// assertions on the positioning command link between master and device
`timescale 1ns/1ns
`default_nettype none
module motion_link_sva (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic [63:0] frame,
    input wire logic param_wr,
    input wire logic busy,
    input wire logic [1:0] notch,
    input wire logic [4:0] stage
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic [3:0] code;
    assign code = frame[11:8];
    sequence s_rise;
        !frame[0] ##1 frame[0];
    endsequence
    sequence s_take;
        s_rise ##0 (frame[1] && !busy && (code == 4'h3 || code == 4'h4));
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    AST_CODE_LAST: assert property ($rose(frame[0]) |-> frame[1] && code != 4'h0)
        else $error("start raised without code or servo-on");
    AST_CODE_CLEARED: assert property ($changed(code) && code != 4'h0 |-> $past(code) == 4'h0)
        else $error("code replaced without clearing");
    AST_DATA_FIRST: assert property ($rose(frame[0]) |-> $stable(frame[63:24]))
        else $error("target or select moved at start");
    AST_TAKE_BUSY: assert property (s_take |=> busy)
        else $error("valid start not taken");
    AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(frame[0]) && !$past(frame[0], 2))
        else $error("move began without start edge");
    AST_FRESH_START: assert property ($rose(busy) |-> stage == 5'h00 && notch == 2'b00)
        else $error("stage or notch not cleared at start");
    AST_STAGE_STEP: assert property (busy && $past(busy) && $changed(stage)
        |-> stage == $past(stage) + 5'h01)
        else $error("stage skipped");
    AST_STAGE_LIMIT: assert property (stage <= 5'h10)
        else $error("stage above sixteen");
    AST_SETTINGS_QUIET: assert property (param_wr |-> !busy)
        else $error("settings written during a move");
    AST_NOTCH_STICKY: assert property (busy && $past(busy)
        |-> (notch & $past(notch)) == $past(notch))
        else $error("notch dropped during a move");
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench joining master and device ends over the link
`timescale 1ns/1ns
`default_nettype none
`include "motion_regs.svh"
module testbench;
    import motion_pkg::*;
    logic SYS_CLK, SYS_RST, HSEL, HWRITE, HREADYOUT, HRESP, AXIS_DONE, AXIS_GO, AXIS_RUN;
    logic [31:0] HADDR, HWDATA, HRDATA, rd;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    pos_t AXIS_POS, AXIS_TARGET;
    speed_t AXIS_SPEED;
    logic go, multi;
    int miscompares, check_count, cnt, feed, ppos, st, tgt;
    int spos[16], sspd[16], npos[2];
    motion_if i_motion_if();
    motion_mst i_motion_mst(.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .LINK(i_motion_if.mst));
    motion_dev i_motion_dev(.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .LINK(i_motion_if.dev),
        .AXIS_POS(AXIS_POS), .AXIS_DONE(AXIS_DONE), .AXIS_TARGET(AXIS_TARGET),
        .AXIS_SPEED(AXIS_SPEED), .AXIS_GO(AXIS_GO), .AXIS_RUN(AXIS_RUN));
    motion_link_sva i_motion_link_sva(.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
        .frame(i_motion_if.frame), .param_wr(i_motion_if.param_wr), .busy(i_motion_if.busy),
        .notch(i_motion_if.notch), .stage(i_motion_if.stage));
    ////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word transfer; no fixed latency assumed
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h00_0000, a};
        HWRITE <= wr;
        HSIZE <= 3'b010;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        rd = HRDATA;
    endtask
    // model drops values outside the legal ranges, and every write during a move
    task automatic setp(input int idx, input int v);
        ahb(1'b1, `REG_PIDX, 32'(idx));
        ahb(1'b1, `REG_PDATA, 32'(v));
        if (go === 1'b1) return;
        if (idx == 0 && v >= 0 && v <= 16) cnt = v;
        if (idx == 1 && v >= 1 && v <= 240000) feed = v;
        if (idx >= 2 && idx < 18 && v >= 0 && v <= 99999999) spos[idx-2] = v;
        if (idx >= 18 && idx < 34 && v >= 1 && v <= 240000) sspd[idx-18] = v;
        if (idx >= 34 && idx < 36) npos[idx-34] = v;
    endtask
    task automatic cmd(input logic [3:0] code, input logic inc, input int d);
        int n;
        ahb(1'b1, `REG_TARGET, 32'(d));
        ahb(1'b1, `REG_CMD, {23'h00_0000, 1'b1, 3'h0, inc, code});
        n = 0;
        while (AXIS_GO !== 1'b1 && n < 12) begin
            @(posedge SYS_CLK);
            n++;
        end
        go = (AXIS_GO === 1'b1);
        st = ppos;
        tgt = inc ? ppos + d : d;
        ahb(1'b0, `REG_TARGET, 32'h0000_0000);
        chk(rd, 32'(d));
    endtask
    // move the axis and compare stage, speed and notch with the model
    task automatic mv(input int p);
        int ns;
        int nb;
        ns = 0;
        nb = 0;
        AXIS_POS <= p;
        ppos = p;
        repeat (4) @(posedge SYS_CLK);
        for (int k = 0; k < cnt; k++) if (multi && ppos >= spos[k]) ns++;
        for (int j = 0; j < 2; j++) begin
            if (!multi && ((st > npos[j] && p <= npos[j]) || (st < npos[j] && p >= npos[j])))
                nb = nb | (1 << j);
        end
        ahb(1'b0, `REG_STATUS, 32'h0000_0000);
        chk(32'(rd[7:3]), ns);
        chk(32'(rd[2:1]), nb);
        chk(32'(AXIS_SPEED), ns == 0 ? feed : sspd[ns-1]);
        ahb(1'b0, `REG_POS, 32'h0000_0000);
        chk(rd, 32'(ppos));
    endtask
    task automatic finish_move();
        AXIS_DONE <= 1'b1;
        @(posedge SYS_CLK);
        AXIS_DONE <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        chk(32'(AXIS_RUN), 0);
        go = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end
    // whole run is a few hundred cycles
    initial begin
        #400000;
        miscompares++;
        summarize();
    end
    initial begin
        SYS_RST = 1'b1;
        HSEL = 1'b0;
        HTRANS = 2'b00;
        HADDR = 32'h0000_0000;
        HWRITE = 1'b0;
        HSIZE = 3'b010;
        HWDATA = 32'h0000_0000;
        AXIS_POS = 0;
        AXIS_DONE = 1'b0;
        miscompares = 0;
        check_count = 0;
        cnt = 0;
        feed = 24000;
        ppos = 0;
        npos = '{0, 0};
        foreach (spos[k]) begin
            spos[k] = 0;
            sspd[k] = 24000;
        end
        void'($urandom(32'h0000_a436));
        repeat (20) @(posedge SYS_CLK);
        SYS_RST <= 1'b0;
        @(posedge SYS_CLK);
        chk(32'(AXIS_SPEED), feed);
        ahb(1'b0, 8'h40, 32'h0000_0000);
        chk(rd, 0);
        setp(0, 17);
        setp(0, 3);
        setp(1, 1 + $urandom % 240000);
        for (int k = 0; k < 4; k++) begin
            setp(2 + k, 100 * (k + 1) + $urandom % 50);
            setp(18 + k, 1 + $urandom % 240000);
        end
        setp(18, 240000);
        setp(19, 0);
        setp(20, 240001);
        setp(5, 100000000);
        cmd(4'h5, 1'b0, 1000);
        chk(32'(go), 0);
        multi = 1'b1;
        cmd(4'h4, 1'b0, 1000);
        chk(32'(go), 1);
        chk(AXIS_TARGET, tgt);
        chk(i_motion_if.frame[63:32], 1000);
        chk(32'(i_motion_if.frame[11:8]), 4);
        chk(32'(AXIS_SPEED), feed);
        // a stage speed change in mid-move must not reach the third stage
        setp(20, 7);
        for (int k = 0; k < 4; k++) mv(spos[k]);
        mv(700);
        finish_move();
        setp(34, 400);
        setp(35, 100);
        multi = 1'b0;
        cmd(4'h3, 1'b1, -500);
        chk(32'(go), 1);
        chk(AXIS_TARGET, tgt);
        chk(32'(i_motion_if.frame[24]), 1);
        mv(500);
        mv(400);
        mv(200);
        finish_move();
        summarize();
    end
endmodule
`default_nettype wire
